/* File: hdl/uerx_dev.sv */
// Device end: receive endpoint with FIFO and a DMA engine writing bytes to memory.
// Assumes memory accepts one byte write per cycle when mem_ready is high.
// Summary of operation
// - Software configures DMA before host transfer starts
// - Size change during active transfer locks DMA
// - Empty FIFO accepts data; DMA drains it
// - Software never changes DMA settings mid-transfer
// - Host leaves idle gap between generic transfers
// - Use pass-through mode for back-to-back transfers
// - Pass-through interrupts per packet; generic per transfer
// - Isochronous endpoint interrupts on every packet
//
// Chosen here: the strobed register port and the placing of the registers.
`default_nettype none
module uerx_dev
   import uerx_pkg::*;
(
   input  wire logic              sys_clk,   // Clock
   input  wire logic              rst,       // Async reset
   input  wire logic              clk_en,    // Freeze when low
   uerx_link_if.dev               link,      // Link from host end
   input  wire logic [3:0]        reg_addr,  // Register index
   input  wire logic [31:0]       reg_wdata, // Write data
   input  wire logic              reg_wr,    // Write strobe
   input  wire logic              reg_rd,    // Read strobe
   output logic      [31:0]       reg_rdata, // Read data, cycle after strobe
   output logic                   mem_we,    // Memory byte write
   output logic      [ADDR_W-1:0] mem_addr,  // Memory byte address
   output logic      [BYTE_W-1:0] mem_wdata, // Memory byte data
   input  wire logic              mem_ready, // Memory accepts write
   output logic                   irq        // Interrupt pulse
);

   typedef enum logic [1:0] {S_IDLE, S_RUN, S_LOCK} uerx_dst_t;
   typedef struct packed {
      uerx_dst_t         state;
      logic              enable;
      logic              mode;
      logic              iso;
      logic [SIZE_W-1:0] size;
      logic [ADDR_W-1:0] base;
      logic [SIZE_W-1:0] count;
      logic [SIZE_W-1:0] pkt_cnt;
      logic [15:0]       events;
      logic              mem_we;
      logic [ADDR_W-1:0] mem_addr;
      logic [BYTE_W-1:0] mem_wdata;
      logic              irq;
      logic [31:0]       rdata;
   } uerx_dev_st_t;

   uerx_dev_st_t st_reg, st_next;
   logic              f_valid, f_ready, f_last;
   logic [BYTE_W-1:0] f_data;
   logic              take;
   logic              pkt_done, xfer_done;
   logic              fifo_in_ready;
   logic              per_pkt;
   logic [31:0]       ctrl_word;
   logic [31:0]       stat_word;

   // Bytes offered while disabled are held back by ready, never dropped
   uerx_fifo #(.WIDTH(BYTE_W + 1), .DEPTH(FIFO_DEPTH)) uerx_fifo_i (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .in_valid (link.valid && st_reg.enable),
      .in_ready (fifo_in_ready),
      .in_data  ({link.last, link.data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data ({f_last, f_data})
   );

   // Drain only while running and the memory side can take the byte
   assign f_ready = (st_reg.state == S_RUN) && (!st_reg.mem_we || mem_ready);
   assign take    = f_valid && f_ready;
   assign pkt_done  = take && f_last;
   // Short packet: packet ends before reaching full packet length
   assign xfer_done = take && ((st_reg.count + 1'b1 == st_reg.size) ||
                     (f_last && (st_reg.pkt_cnt + 1'b1 < SIZE_W'(PKT_MAX))));

   assign mem_we    = st_reg.mem_we;
   assign mem_addr  = st_reg.mem_addr;
   assign mem_wdata = st_reg.mem_wdata;
   assign irq       = st_reg.irq;
   assign reg_rdata = st_reg.rdata;
   assign link.ready = fifo_in_ready && st_reg.enable;
   // Isochronous endpoints always count a packet as a whole transfer
   assign per_pkt   = (st_reg.mode == UERX_PASSTHRU) || st_reg.iso;

   // Control and status words are built once so every field keeps its bit
   always_comb begin
      stat_word = '0;
      stat_word[STAT_BUSY_BIT] = st_reg.state == S_RUN;
      stat_word[STAT_LOCK_BIT] = st_reg.state == S_LOCK;
      stat_word[STAT_IRQ_BIT]  = st_reg.irq;
      ctrl_word = '0;
      ctrl_word[CTRL_EN_BIT]   = st_reg.enable;
      ctrl_word[CTRL_MODE_BIT] = st_reg.mode;
      ctrl_word[CTRL_ISO_BIT]  = st_reg.iso;
   end

   always_comb begin
      st_next = st_reg;
      st_next.irq = 1'b0;
      st_next.rdata = '0;
      // A byte stays on the memory port until memory takes it
      if (st_reg.mem_we && mem_ready) st_next.mem_we = 1'b0;

      if (reg_wr) begin
         unique case (reg_addr)
            REG_CTRL: begin
               st_next.enable = reg_wdata[CTRL_EN_BIT];
               st_next.mode   = reg_wdata[CTRL_MODE_BIT];
               st_next.iso    = reg_wdata[CTRL_ISO_BIT];
            end
            REG_SIZE: begin
               // A size rewrite mid-transfer collides with the live count
               if (st_reg.state == S_RUN && st_reg.count != '0 &&
                   reg_wdata[SIZE_W-1:0] != st_reg.size) st_next.state = S_LOCK;
               st_next.size = reg_wdata[SIZE_W-1:0];
            end
            REG_ADDR: begin
               st_next.base = reg_wdata;
            end
            REG_EVENTS: begin
               st_next.events = '0;
            end
            default: ;
         endcase
      end

      if (reg_rd) begin
         unique case (reg_addr)
            REG_CTRL: begin
               st_next.rdata = ctrl_word;
            end
            REG_SIZE: begin
               st_next.rdata = {16'h0, st_reg.size};
            end
            REG_ADDR: begin
               st_next.rdata = st_reg.base;
            end
            REG_STAT: begin
               st_next.rdata = stat_word;
            end
            REG_COUNT: begin
               st_next.rdata = {16'h0, st_reg.count};
            end
            REG_EVENTS: begin
               st_next.rdata = {16'h0, st_reg.events};
            end
            default: begin
               st_next.rdata = '0;
            end
         endcase
      end

      unique case (st_reg.state)
         S_IDLE: begin
            // Configuration is taken as valid once enabled (software duty)
            if (st_reg.enable && f_valid) begin
               st_next.state = S_RUN;
               st_next.count = '0;
               st_next.pkt_cnt = '0;
            end
         end
         S_RUN: begin
            if (take) begin
               st_next.mem_we    = 1'b1;
               st_next.mem_addr  = st_reg.base + ADDR_W'(st_reg.count);
               st_next.mem_wdata = f_data;
               st_next.count     = st_reg.count + 1'b1;
               st_next.pkt_cnt   = f_last ? '0 : st_reg.pkt_cnt + 1'b1;
               if (per_pkt) begin
                  // Next packet lands right after this one in memory
                  if (pkt_done) begin
                     st_next.irq = 1'b1;
                     st_next.events = st_reg.events + 1'b1;
                     st_next.state = S_IDLE;
                     st_next.base = st_reg.base + ADDR_W'(st_reg.count) + 1'b1;
                  end
               end else if (xfer_done) begin
                  // Base stays put: software programs it for the next transfer
                  st_next.irq = 1'b1;
                  st_next.events = st_reg.events + 1'b1;
                  st_next.state = S_IDLE;
               end
            end
         end

         S_LOCK: begin
            // Only clearing enable recovers the engine
            if (reg_wr && reg_addr == REG_CTRL && !reg_wdata[CTRL_EN_BIT]) begin
               st_next.state = S_IDLE;
            end
         end
         default: st_next.state = S_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/uerx_pkg.sv */
// Package for the endpoint receive DMA: link framing, modes, register map, counts.
// Assumes one clock domain (sys_clk) shared by both ends.
`default_nettype none
package uerx_pkg;
   localparam int BYTE_W        = 8;
   localparam int FIFO_DEPTH    = 4;
   localparam int SIZE_W        = 16;
   localparam int ADDR_W        = 32;
   localparam int PKT_MAX       = 64;
   localparam int IDLE_GAP_CYC  = 8;
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_SIZE   = 4'h1;
   localparam logic [3:0] REG_ADDR   = 4'h2;
   localparam logic [3:0] REG_STAT   = 4'h3;
   localparam logic [3:0] REG_COUNT  = 4'h4;
   localparam logic [3:0] REG_EVENTS = 4'h5;
   localparam logic [3:0] HREG_CMD   = 4'h0;
   localparam logic [3:0] HREG_LEN   = 4'h1;
   localparam logic [3:0] HREG_STAT  = 4'h2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CTRL_EN_BIT   = 0;
   localparam int CTRL_MODE_BIT = 1;
   localparam int CTRL_ISO_BIT  = 2;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LOCK_BIT = 1;
   localparam int STAT_IRQ_BIT  = 2;
   typedef enum logic {UERX_GENERIC, UERX_PASSTHRU} uerx_mode_t;
endpackage
`default_nettype wire

/* File: hdl/uerx_link_if.sv */
// Link between the host end and the device endpoint: byte stream with packet end marks.
// Assumes both ends are clocked by the same sys_clk.
`default_nettype none
interface uerx_link_if;
   import uerx_pkg::*;
   logic              valid;
   logic              ready;
   logic [BYTE_W-1:0] data;
   logic              last;
   logic              xfer_end;
   modport host (output valid, output data, output last, output xfer_end, input ready);
   modport dev  (input valid, input data, input last, input xfer_end, output ready);
endinterface
`default_nettype wire

/* File: hdl/uerx_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and clock enable; DEPTH a power of two.
`default_nettype none
module uerx_fifo
   import uerx_pkg::*;
#(
   parameter int WIDTH = 9,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             sys_clk,   // Clock
   input  wire logic             rst,       // Async reset
   input  wire logic             clk_en,    // Freeze when low
   input  wire logic             in_valid,  // Write request
   output logic                  in_ready,  // Not full
   input  wire logic [WIDTH-1:0] in_data,   // Write data
   output logic                  out_valid, // Not empty
   input  wire logic             out_ready, // Read accept
   output logic      [WIDTH-1:0] out_data   // Head word
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW:0] wp;
      logic [PW:0] rp;
   } uerx_fifo_st_t;
   uerx_fifo_st_t    st_reg, st_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             full, empty;

   assign empty     = st_reg.wp == st_reg.rp;
   assign full      = (st_reg.wp[PW] != st_reg.rp[PW]) && (st_reg.wp[PW-1:0] == st_reg.rp[PW-1:0]);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = mem[st_reg.rp[PW-1:0]];

   always_comb begin
      st_next = st_reg;
      if (in_valid && !full) st_next.wp = st_reg.wp + 1'b1;
      if (out_ready && !empty) st_next.rp = st_reg.rp + 1'b1;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (clk_en && in_valid && !full) begin
         mem[st_reg.wp[PW-1:0]] <= in_data;
      end
   end
endmodule
`default_nettype wire

/* File: hdl/uerx_host.sv */
// Host end: sends a transfer of LEN bytes split into packets, then waits an idle gap.
// Assumes the device end accepts bytes via link.ready.
`default_nettype none
module uerx_host
   import uerx_pkg::*;
(
   input  wire logic        sys_clk,   // Clock
   input  wire logic        rst,       // Async reset
   input  wire logic        clk_en,    // Freeze when low
   uerx_link_if.host        link,      // Link to device end
   input  wire logic [3:0]  reg_addr,  // Register index
   input  wire logic [31:0] reg_wdata, // Write data
   input  wire logic        reg_wr,    // Write strobe
   input  wire logic        reg_rd,    // Read strobe
   output logic      [31:0] reg_rdata  // Read data, cycle after strobe
);
   typedef enum logic [1:0] {H_IDLE, H_SEND, H_GAP} uerx_hst_t;
   typedef struct packed {
      uerx_hst_t         state;
      logic [SIZE_W-1:0] len;
      logic [SIZE_W-1:0] sent;
      logic [SIZE_W-1:0] pkt;
      logic [7:0]        gap;
      logic [BYTE_W-1:0] data;
      logic [31:0]       rdata;
   } uerx_host_st_t;
   uerx_host_st_t st_reg, st_next;
   logic last_byte, pkt_end;

   assign last_byte     = st_reg.sent + 1'b1 == st_reg.len;
   assign pkt_end       = last_byte || (st_reg.pkt + 1'b1 == SIZE_W'(PKT_MAX));
   assign link.valid    = st_reg.state == H_SEND;
   assign link.data     = st_reg.data;
   assign link.last     = (st_reg.state == H_SEND) && pkt_end;
   assign link.xfer_end = (st_reg.state == H_SEND) && last_byte;
   assign reg_rdata     = st_reg.rdata;

   always_comb begin
      st_next = st_reg;
      st_next.rdata = '0;
      if (reg_wr && reg_addr == HREG_LEN) st_next.len = reg_wdata[SIZE_W-1:0];
      if (reg_rd) begin
         st_next.rdata = (reg_addr == HREG_STAT) ? {30'h0, st_reg.state} :
                         (reg_addr == HREG_LEN) ? {16'h0, st_reg.len} : '0;
      end
      unique case (st_reg.state)
         H_IDLE: begin
            if (reg_wr && reg_addr == HREG_CMD && reg_wdata[0] && st_reg.len != '0) begin
               st_next.state = H_SEND;
               st_next.sent = '0;
               st_next.pkt = '0;
               st_next.data = '0;
            end
         end
         H_SEND: begin
            if (link.ready) begin
               st_next.sent = st_reg.sent + 1'b1;
               st_next.pkt  = pkt_end ? '0 : st_reg.pkt + 1'b1;
               st_next.data = st_reg.data + 1'b1;
               if (last_byte) begin
                  st_next.state = H_GAP;
                  st_next.gap = 8'(IDLE_GAP_CYC);
               end
            end
         end
         H_GAP: begin
            // Idle time lets device software reprogram the next size
            st_next.gap = st_reg.gap - 1'b1;
            if (st_reg.gap == 8'h01) st_next.state = H_IDLE;
         end
         default: st_next.state = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire

/* File: sim/uerx_link_sva.sv */
// Assertions on the link that joins the host end to the device end.
// Assumes clk_en held high, so an accepted byte moves the host on the next edge.
`default_nettype none
module uerx_link_sva
   import uerx_pkg::*;
(
   input wire logic              sys_clk,  // Clock
   input wire logic              rst,      // Async reset
   input wire logic              valid,    // Byte offered
   input wire logic              ready,    // Byte taken
   input wire logic [BYTE_W-1:0] data,     // Byte value
   input wire logic              last,     // Packet end
   input wire logic              xfer_end  // Transfer end
);
   logic [7:0] pkt_cnt_reg;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pkt_cnt_reg <= 8'h00;
      end else if (valid && ready) begin
         pkt_cnt_reg <= last ? 8'h00 : pkt_cnt_reg + 8'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_take_end; valid && ready && xfer_end; endsequence
   sequence s_start; !valid ##1 valid; endsequence
   property p_hold; valid && !ready |=> valid && $stable(data) && $stable(last); endproperty
   a_hold: assert property (p_hold) else $error("byte changed before taken");
   property p_inc; valid && ready && !xfer_end |=> valid && data == $past(data) + 8'h01;
   endproperty
   a_inc: assert property (p_inc) else $error("byte sequence broken");
   property p_start; s_start |-> data == 8'h00; endproperty
   a_start: assert property (p_start) else $error("transfer not starting at zero");
   property p_gap; s_take_end |=> !valid [*8]; endproperty
   a_gap: assert property (p_gap) else $error("idle gap too short");
   property p_pkt_max; valid && ready |-> pkt_cnt_reg < 8'(PKT_MAX); endproperty
   a_pkt_max: assert property (p_pkt_max) else $error("packet too long");
   property p_full_pkt; valid && ready && last && !xfer_end |-> pkt_cnt_reg == 8'(PKT_MAX - 1);
   endproperty
   a_full_pkt: assert property (p_full_pkt) else $error("short packet mid transfer");
   property p_end_last; xfer_end |-> last; endproperty
   a_end_last: assert property (p_end_last) else $error("transfer end without packet end");
   property p_last_valid; last |-> valid; endproperty
   a_last_valid: assert property (p_last_valid) else $error("packet end without byte");
endmodule
`default_nettype wire

/* File: sim/usb_endpoint_rx_dma_modes_tb.sv */
// Bench: host end and device end joined by the link, both run through their registers.
// Assumes one 100 MHz clock; memory stalls 3 cycles of every 8.
`default_nettype none
module usb_endpoint_rx_dma_modes_tb
   import uerx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   logic              mem_ready = 1'b0;
   logic [3:0]        reg_addr = 4'h0;
   logic [31:0]       reg_wdata = 32'h0;
   logic              h_wr = 1'b0, h_rd = 1'b0, d_wr = 1'b0, d_rd = 1'b0;
   logic [31:0]       h_rdata, d_rdata, base_addr = 32'h0;
   logic              mem_we, irq, mon_on = 1'b0;
   logic [ADDR_W-1:0] mem_addr;
   logic [BYTE_W-1:0] mem_wdata;
   logic [2:0]        stall_cnt = 3'h0;
   int                irq_cnt = 0, err_count = 0, total_checks = 0;
   always #5 sys_clk = ~sys_clk;
   uerx_link_if link_i ();
   uerx_host uerx_host_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .link(link_i),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(h_wr), .reg_rd(h_rd),
      .reg_rdata(h_rdata));
   uerx_dev uerx_dev_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .link(link_i),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(d_wr), .reg_rd(d_rd),
      .reg_rdata(d_rdata), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_ready(mem_ready), .irq(irq));
   uerx_link_sva uerx_link_sva_i (.sys_clk(sys_clk), .rst(rst), .valid(link_i.valid),
      .ready(link_i.ready), .data(link_i.data), .last(link_i.last), .xfer_end(link_i.xfer_end));
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Memory byte must equal its offset from the base: the host counts up from zero
   always @(posedge sys_clk) begin
      stall_cnt <= stall_cnt + 3'h1;
      mem_ready <= (stall_cnt < 3'h5);
      if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
      if (mon_on && mem_we === 1'b1 && mem_ready) begin
         chk("mem_wdata", 32'(mem_addr[7:0] - base_addr[7:0]), 32'(mem_wdata));
      end
   end
   task automatic wr(input logic dev, input logic [3:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      h_wr <= !dev;
      d_wr <= dev;
      @(posedge sys_clk);
      h_wr <= 1'b0;
      d_wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic dev, input logic [3:0] a, output logic [31:0] v);
      reg_addr <= a;
      h_rd <= !dev;
      d_rd <= dev;
      @(posedge sys_clk);
      h_rd <= 1'b0;
      d_rd <= 1'b0;
      #1 v = dev ? d_rdata : h_rdata;
      @(posedge sys_clk);
   endtask
   task automatic xfer(input logic [31:0] ctrl, size, len, n_irq, input logic gen);
      int          irq0;
      logic [31:0] v;
      logic        done;
      irq0 = irq_cnt;
      done = 1'b0;
      base_addr <= len << 4;
      mon_on <= 1'b1;
      wr(1'b1, REG_SIZE, size);
      wr(1'b1, REG_ADDR, len << 4);
      wr(1'b1, REG_EVENTS, 32'h0);
      wr(1'b1, REG_CTRL, ctrl);
      wr(1'b0, HREG_LEN, len);
      wr(1'b0, HREG_CMD, 32'h1);
      for (int i = 0; i < 400 && !done; i++) begin
         rd(1'b0, HREG_STAT, v);
         done = (v === 32'h0) && (irq_cnt - irq0 >= int'(n_irq));
      end
      if (!done) begin
         chk("xfer_timeout", 32'h1, 32'h0);
         print_verdict();
      end
      repeat (16) @(posedge sys_clk);
      chk("irq_count", n_irq, 32'(irq_cnt - irq0));
      rd(1'b1, REG_EVENTS, v);
      chk("events_reg", n_irq, v);
      if (gen) begin
         rd(1'b1, REG_COUNT, v);
         chk("count_reg", len, v);
      end
   endtask
   task automatic lock_case();
      logic [31:0] v;
      mon_on <= 1'b0;
      wr(1'b1, REG_SIZE, 32'h0c8);
      wr(1'b1, REG_CTRL, 32'h1);
      wr(1'b0, HREG_LEN, 32'h0c8);
      wr(1'b0, HREG_CMD, 32'h1);
      repeat (20) @(posedge sys_clk);
      wr(1'b1, REG_SIZE, 32'h064);
      rd(1'b1, REG_STAT, v);
      chk("lock_bit", 32'h1, 32'(v[STAT_LOCK_BIT]));
      wr(1'b1, REG_CTRL, 32'h0);
      rd(1'b1, REG_STAT, v);
      chk("lock_clear", 32'h0, 32'(v[STAT_LOCK_BIT]));
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask
   initial begin
      logic [31:0] v;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rd(1'b1, REG_CTRL, v);
      chk("ctrl_reset", CTRL_RESET, v);
      rd(1'b1, 4'hf, v);
      chk("unmapped", 32'h0, v);
      xfer(32'h1, 32'h064, 32'h064, 32'h1, 1'b1);
      xfer(32'h1, 32'h0c8, 32'h046, 32'h1, 1'b1);
      xfer(32'h3, 32'h0c8, 32'h082, 32'h3, 1'b0);
      xfer(32'h3, 32'h0c8, 32'h040, 32'h1, 1'b0);
      xfer(32'h5, 32'h200, 32'h080, 32'h2, 1'b0);
      lock_case();
      xfer(32'h1, 32'h040, 32'h040, 32'h1, 1'b1);
      print_verdict();
   end
endmodule
`default_nettype wire
